/* File: hbc_pkg.sv */
// hbc_pkg: register map, field positions and reset values of the hardware breakpoint compare unit
// assumes a 32-bit AXI4-Lite register port, one register per aligned word
package hbc_pkg;
	// printed offsets are not all multiples of four: they are word indices
	localparam logic [7:0] IDX_CTRL0 = 8'h20;
	localparam logic [7:0] IDX_CTRL1 = 8'h21;
	localparam logic [7:0] IDX_ADDR_HI = 8'h22;
	localparam logic [7:0] IDX_ADDR_LO = 8'h23;
	localparam logic [7:0] IDX_DATA_HI = 8'h24;
	localparam logic [7:0] IDX_DATA_LO = 8'h25;
	localparam logic [7:0] IDX_STATUS = 8'h26;
	localparam int ADDR_W = 10;
	// control 0 fields
	localparam int C0_MODE_HI = 7;
	localparam int C0_MODE_LO = 6;
	localparam int C0_PROG_ONLY = 5;
	localparam int C0_SECOND_RANGE = 3;
	localparam int C0_FIRST_RANGE = 2;
	localparam logic [7:0] C0_MASK = 8'hEC;
	// control 1 fields
	localparam int C1_DATA_EN = 6;
	localparam int C1_HI_MASK = 5;
	localparam int C1_LO_MASK = 4;
	localparam int C1_SECOND_DIR_EN = 3;
	localparam int C1_SECOND_DIR_VAL = 2;
	localparam int C1_FIRST_DIR_EN = 1;
	localparam int C1_FIRST_DIR_VAL = 0;
	localparam logic [7:0] C1_MASK = 8'h7F;
	localparam logic [7:0] REG_RESET = 8'h00;
	// status fields
	localparam int ST_FIRST_HIT = 0;
	localparam int ST_SECOND_HIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		HBC_MODE_OFF,
		HBC_MODE_SWI_DUAL,
		HBC_MODE_BDM_FULL,
		HBC_MODE_BDM_DUAL
	} hbc_mode_t;
endpackage

/* File: hbc_top.sv */
// hbc_top: breakpoint comparator watching the core address, data and direction buses
// assumes bus inputs synchronous to sys_clk, one core bus cycle per bus_valid pulse
`timescale 1ns/100ps

// Notes on behaviour
// R1: mode field: off, dual address soft interrupt, full debug, dual address debug.
// R2: debug entry by breakpoint only while debug-enabled input is high.
// R3: no breakpoints at all while background debug is active.
// R4: full mode compares address registers to address, data registers to data, with qualifiers.
// R5: dual modes use data registers as second address compare, enabled by data enable.
// R6: program-only bit: break only on executed tagged opcode, else next boundary.
// R7: soft interrupt dual mode: program breakpoints only, direction ignored.
// R8: first range bit: clear compares high address byte only, set adds low byte.
// R9: second range bit: clear high byte only, set adds low data byte compare.
// R10: data enable clear removes data registers from every comparison.
// R11: full mode high mask bit excludes data bits 15:8.
// R12: full mode low mask bit excludes data bits 7:0.
// R13: first direction check enable and value: 0 matches write, 1 matches read.
// R14: second direction check enable and value qualify second dual breakpoint.
// R15: address high byte to address 15:8, address low byte to 7:0.
// R16: data high byte against data 15:8, or address 15:8 in dual modes.
// R17: control registers always read/write, all reset zero, unused bits read zero.
// R18: software should not arm debug breaks without the debug enable set.
// R19: data low byte against data 7:0, or address 7:0 in dual modes.
// R20: soft interrupt dual mode ignores both direction bits for both breakpoints.
// R21: tagged opcode enters debug at queue head instead of executing.
// R22: qualified match gives one-cycle soft interrupt or debug entry request.
// R23: match needs all enabled byte compares and direction check in same cycle.
module hbc_top (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] cpu_addr,
	input wire logic [15:0] cpu_data,
	input wire logic cpu_read,
	input wire logic bus_valid,
	input wire logic program_fetch,
	input wire logic background_debug_enabled,
	input wire logic background_debug_active,
	output logic software_interrupt_req,
	output logic background_debug_req,
	output logic tag_fetch
);
	logic [7:0] break_control_0_reg;
	logic [7:0] break_control_1_reg;
	logic [7:0] break_address_high_reg;
	logic [7:0] break_address_low_reg;
	logic [7:0] break_data_high_reg;
	logic [7:0] break_data_low_reg;
	logic [1:0] hit_status_reg;
	logic aw_held_reg;
	logic w_held_reg;
	logic [31:0] awaddr_reg;
	logic [7:0] wdata_reg;
	logic wstrb0_reg;
	logic wr_go;
	logic wr_ok;
	logic [7:0] wr_idx;
	logic [7:0] rd_idx;
	logic rd_ok;
	logic [7:0] rd_val;
	hbc_pkg::hbc_mode_t mode;
	logic dual_mode;
	logic first_range_full;
	logic second_range_full;
	logic data_compare_enable;
	logic high_byte_mask;
	logic low_byte_mask;
	logic program_address_only;
	logic first_dir_ok;
	logic second_dir_ok;
	logic first_hi_eq;
	logic first_lo_eq;
	logic second_hi_eq;
	logic second_lo_eq;
	logic first_hit;
	logic second_hit;
	logic any_hit;
	logic armed;
	logic hit_is_swi;
	logic direct_break;
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic reg_we;
	logic [1:0] wr_resp;
	logic [31:0] rd_word;
	logic [1:0] rd_resp;
	logic data_hi_eq;
	logic data_lo_eq;
	logic full_data_ok;
	logic first_addr_ok;
	logic second_addr_ok;
	logic [1:0] status_clr;
	logic [1:0] status_set;
	logic tag_fetch_next;
	logic software_interrupt_next;
	logic background_debug_next;
	localparam int ADDR_W_HI = hbc_pkg::ADDR_W - 1;

	// register bus
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	// address and data come in either order; the write fires once both are in
	assign wr_go = (aw_held_reg || aw_take) && (w_held_reg || w_take) && !s_axi_bvalid;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			aw_held_reg <= 1'b0;
		end else if (wr_go) begin
			aw_held_reg <= 1'b0;
		end else if (aw_take) begin
			aw_held_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			awaddr_reg <= 32'h0000_0000;
		end else if (aw_take) begin
			awaddr_reg <= s_axi_awaddr;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			w_held_reg <= 1'b0;
		end else if (wr_go) begin
			w_held_reg <= 1'b0;
		end else if (w_take) begin
			w_held_reg <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wdata_reg <= 8'h00;
			wstrb0_reg <= 1'b0;
		end else if (w_take) begin
			wdata_reg <= s_axi_wdata[7:0];
			wstrb0_reg <= s_axi_wstrb[0];
		end
	end

	logic [31:0] wr_addr;
	logic [7:0] wr_byte;
	logic wr_lane0;
	assign wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
	assign wr_byte = w_held_reg ? wdata_reg : s_axi_wdata[7:0];
	assign wr_lane0 = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
	assign wr_idx = wr_addr[ADDR_W_HI:2];
	assign wr_ok = (wr_addr[31:hbc_pkg::ADDR_W] == '0)
		&& (wr_idx >= hbc_pkg::IDX_CTRL0) && (wr_idx <= hbc_pkg::IDX_STATUS);
	assign wr_resp = wr_ok ? hbc_pkg::RESP_OKAY : hbc_pkg::RESP_SLVERR;
	// a cleared lane 0 strobe completes the write but changes nothing
	assign reg_we = wr_go && wr_ok && wr_lane0;

	// response stands until the master takes it
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bvalid <= 1'b0;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_bresp <= hbc_pkg::RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bresp <= wr_resp;
		end
	end

	// control and compare registers, writable any time; unused control bits stay zero
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			break_control_0_reg <= hbc_pkg::REG_RESET; // R17
		end else if (reg_we && wr_idx == hbc_pkg::IDX_CTRL0) begin
			break_control_0_reg <= wr_byte & hbc_pkg::C0_MASK; // R17
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			break_control_1_reg <= hbc_pkg::REG_RESET; // R17
		end else if (reg_we && wr_idx == hbc_pkg::IDX_CTRL1) begin
			break_control_1_reg <= wr_byte & hbc_pkg::C1_MASK; // R17
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			break_address_high_reg <= hbc_pkg::REG_RESET; // R17
		end else if (reg_we && wr_idx == hbc_pkg::IDX_ADDR_HI) begin
			break_address_high_reg <= wr_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			break_address_low_reg <= hbc_pkg::REG_RESET; // R17
		end else if (reg_we && wr_idx == hbc_pkg::IDX_ADDR_LO) begin
			break_address_low_reg <= wr_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			break_data_high_reg <= hbc_pkg::REG_RESET; // R17
		end else if (reg_we && wr_idx == hbc_pkg::IDX_DATA_HI) begin
			break_data_high_reg <= wr_byte;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			break_data_low_reg <= hbc_pkg::REG_RESET; // R17
		end else if (reg_we && wr_idx == hbc_pkg::IDX_DATA_LO) begin
			break_data_low_reg <= wr_byte;
		end
	end

	assign s_axi_arready = !s_axi_rvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	assign rd_idx = s_axi_araddr[ADDR_W_HI:2];
	assign rd_ok = (s_axi_araddr[31:hbc_pkg::ADDR_W] == '0)
		&& (rd_idx >= hbc_pkg::IDX_CTRL0) && (rd_idx <= hbc_pkg::IDX_STATUS);

	always_comb begin
		case (rd_idx)
			hbc_pkg::IDX_CTRL0: rd_val = break_control_0_reg;
			hbc_pkg::IDX_CTRL1: rd_val = break_control_1_reg;
			hbc_pkg::IDX_ADDR_HI: rd_val = break_address_high_reg;
			hbc_pkg::IDX_ADDR_LO: rd_val = break_address_low_reg;
			hbc_pkg::IDX_DATA_HI: rd_val = break_data_high_reg;
			hbc_pkg::IDX_DATA_LO: rd_val = break_data_low_reg;
			hbc_pkg::IDX_STATUS: rd_val = {6'h00, hit_status_reg};
			default: rd_val = 8'h00;
		endcase
	end

	assign rd_word = rd_ok ? {24'h00_0000, rd_val} : 32'h0000_0000;
	assign rd_resp = rd_ok ? hbc_pkg::RESP_OKAY : hbc_pkg::RESP_SLVERR;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rvalid <= 1'b0;
		end else if (ar_take) begin
			s_axi_rvalid <= 1'b1;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// read data captured with the address, held while rvalid stands
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= hbc_pkg::RESP_OKAY;
		end else if (ar_take) begin
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_resp;
		end
	end

	// comparators
	assign mode = hbc_pkg::hbc_mode_t'({break_control_0_reg[hbc_pkg::C0_MODE_HI],
		break_control_0_reg[hbc_pkg::C0_MODE_LO]}); // R1
	assign dual_mode = (mode == hbc_pkg::HBC_MODE_SWI_DUAL) || (mode == hbc_pkg::HBC_MODE_BDM_DUAL);
	assign program_address_only = break_control_0_reg[hbc_pkg::C0_PROG_ONLY];
	assign first_range_full = break_control_0_reg[hbc_pkg::C0_FIRST_RANGE];
	assign second_range_full = break_control_0_reg[hbc_pkg::C0_SECOND_RANGE];
	assign data_compare_enable = break_control_1_reg[hbc_pkg::C1_DATA_EN];
	assign high_byte_mask = break_control_1_reg[hbc_pkg::C1_HI_MASK];
	assign low_byte_mask = break_control_1_reg[hbc_pkg::C1_LO_MASK];

	assign first_hi_eq = cpu_addr[15:8] == break_address_high_reg; // R15
	assign first_lo_eq = !first_range_full || (cpu_addr[7:0] == break_address_low_reg); // R8 R15
	assign second_hi_eq = cpu_addr[15:8] == break_data_high_reg; // R16
	assign second_lo_eq = !second_range_full || (cpu_addr[7:0] == break_data_low_reg); // R9 R19

	// full mode data compare, each byte maskable
	assign data_hi_eq = high_byte_mask || (cpu_data[15:8] == break_data_high_reg); // R11 R16
	assign data_lo_eq = low_byte_mask || (cpu_data[7:0] == break_data_low_reg); // R12 R19
	assign full_data_ok = !data_compare_enable || (data_hi_eq && data_lo_eq); // R10
	assign first_addr_ok = first_hi_eq && first_lo_eq && first_dir_ok; // R23
	// second breakpoint exists only in the dual modes
	assign second_addr_ok = dual_mode && data_compare_enable // R5 R10
		&& second_hi_eq && second_lo_eq && second_dir_ok; // R14 R23

	// direction checks, dropped in soft interrupt dual mode
	always_comb begin
		first_dir_ok = !break_control_1_reg[hbc_pkg::C1_FIRST_DIR_EN]
			|| (cpu_read == break_control_1_reg[hbc_pkg::C1_FIRST_DIR_VAL]); // R13
		second_dir_ok = !break_control_1_reg[hbc_pkg::C1_SECOND_DIR_EN]
			|| (cpu_read == break_control_1_reg[hbc_pkg::C1_SECOND_DIR_VAL]); // R14
		if (mode == hbc_pkg::HBC_MODE_SWI_DUAL) begin
			first_dir_ok = 1'b1; // R7 R20
			second_dir_ok = 1'b1; // R20
		end
	end

	always_comb begin
		first_hit = 1'b0;
		second_hit = 1'b0;
		case (mode)
			hbc_pkg::HBC_MODE_BDM_FULL: begin
				first_hit = first_addr_ok && full_data_ok; // R4 R23
			end
			hbc_pkg::HBC_MODE_SWI_DUAL, hbc_pkg::HBC_MODE_BDM_DUAL: begin
				first_hit = first_addr_ok; // R23
				second_hit = second_addr_ok; // R5
			end
			default: ;
		endcase
	end

	assign armed = bus_valid && !background_debug_active; // R3
	assign any_hit = armed && (first_hit || second_hit);
	assign hit_is_swi = mode == hbc_pkg::HBC_MODE_SWI_DUAL;
	// soft interrupt mode only breaks on executed program fetches
	assign direct_break = any_hit && !hit_is_swi && !program_address_only; // R6

	// tag the fetched opcode so the core breaks when it reaches the queue head;
	// a tag into debug needs the debug enable just as a direct break does
	assign tag_fetch_next = any_hit && program_fetch
		&& (hit_is_swi || (program_address_only && background_debug_enabled)); // R2 R6 R7 R21
	assign software_interrupt_next = any_hit && hit_is_swi && program_fetch; // R7 R22
	assign background_debug_next = direct_break && background_debug_enabled; // R2 R22

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tag_fetch <= 1'b0;
		end else begin
			tag_fetch <= tag_fetch_next; // R21
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			software_interrupt_req <= 1'b0;
		end else begin
			software_interrupt_req <= software_interrupt_next; // R22
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			background_debug_req <= 1'b0;
		end else begin
			background_debug_req <= background_debug_next; // R22
		end
	end

	// sticky hit flags; a new hit wins over a clear in the same cycle
	assign status_clr = (reg_we && wr_idx == hbc_pkg::IDX_STATUS) ? wr_byte[1:0] : 2'b00;
	assign status_set = {armed && second_hit, armed && first_hit}; // R23

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			hit_status_reg <= 2'b00;
		end else begin
			hit_status_reg <= (hit_status_reg & ~status_clr) | status_set;
		end
	end
endmodule

/* File: hbc_props.sv */
// hbc_props: port-level assertions for hbc_top
// assumes binding onto hbc_top, one sys_clk domain
`timescale 1ns/100ps
module hbc_props (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bus_valid,
	input wire logic program_fetch,
	input wire logic background_debug_enabled,
	input wire logic background_debug_active,
	input wire logic software_interrupt_req,
	input wire logic background_debug_req,
	input wire logic tag_fetch
);
	logic any_req;
	assign any_req = software_interrupt_req || background_debug_req || tag_fetch;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	a_debug_blocks: assert property (bus_valid && background_debug_active |=> !any_req)
		else $error("request while debug active");
	a_idle_quiet: assert property (!bus_valid |=> !any_req)
		else $error("request without bus cycle");
	a_bdm_enable: assert property (background_debug_req |-> $past(background_debug_enabled) && $past(bus_valid))
		else $error("debug request while debug disabled");
	a_swi_fetch: assert property (software_interrupt_req |-> $past(program_fetch) && tag_fetch)
		else $error("soft interrupt not on a fetch");
	a_one_kind: assert property (!(software_interrupt_req && background_debug_req))
		else $error("both request kinds at once");
	a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> s_axi_bvalid)
		else $error("write not answered");
	a_tag_enable: assert property (tag_fetch && !software_interrupt_req |-> $past(background_debug_enabled))
		else $error("debug tag while debug disabled");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read bits set");
	c_swi: cover property (software_interrupt_req);
	c_bdm: cover property (background_debug_req);
	c_tag: cover property (tag_fetch && !software_interrupt_req);
endmodule
bind hbc_top hbc_props u_props (.*);

/* File: hbc_core_model.sv */
// hbc_core_model: core bus side, one strobed bus cycle per call
// assumes caller in sys_clk domain; idle bus shows inverted last values
`timescale 1ns/100ps
module hbc_core_model (
	input wire logic sys_clk,
	output logic [15:0] cpu_addr,
	output logic [15:0] cpu_data,
	output logic cpu_read,
	output logic bus_valid,
	output logic program_fetch,
	input wire logic software_interrupt_req,
	input wire logic background_debug_req,
	input wire logic tag_fetch
);
	initial begin
		{cpu_addr, cpu_data, cpu_read, bus_valid, program_fetch} = '0;
	end
	task automatic cycle(input logic [15:0] a, input logic [15:0] d, input logic r, input logic f, output logic [2:0] g);
		@(posedge sys_clk);
		{cpu_addr, cpu_data, cpu_read, program_fetch, bus_valid} <= {a, d, r, f, 1'b1};
		@(posedge sys_clk);
		{cpu_addr, cpu_data, cpu_read, program_fetch, bus_valid} <= {~a, ~d, ~r, ~f, 1'b0};
		@(negedge sys_clk);
		// tag pulse taken as the queue-head break
		g = {software_interrupt_req, background_debug_req, tag_fetch};
	endtask
endmodule

/* File: test_hw_breakpoint_compare.sv */
// test_hw_breakpoint_compare: register and compare scenarios for hbc_top
// assumes hbc_core_model drives the core bus side
`timescale 1ns/100ps
module test_hw_breakpoint_compare;
	logic sys_clk = 1'b0, rst_b = 1'b0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] cpu_addr, cpu_data;
	logic cpu_read, bus_valid, program_fetch, software_interrupt_req, background_debug_req, tag_fetch;
	logic background_debug_enabled = 1'b0, background_debug_active = 1'b0;
	int num_errors = 0, n_tests = 0;
	always #12.5 sys_clk = ~sys_clk;
	hbc_top u_dut (.*);
	hbc_core_model u_core (.*);
	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] d);
		logic ta, tw, tb;
		logic [1:0] rs;
		@(posedge sys_clk);
		{s_axi_awaddr, s_axi_wdata} <= {22'h0, i, 2'h0, 24'h0, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		tb = 1'b0;
		for (int k = 0; k < 50 && !tb; k++) begin
			@(negedge sys_clk);
			{ta, tw, tb, rs} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge sys_clk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			if (tb) s_axi_bready <= 1'b0;
		end
		if (!tb) begin
			num_errors++;
			test_done();
		end
		chk("bresp", 32'(hbc_pkg::RESP_OKAY), 32'(rs));
	endtask
	task automatic rd(input logic [7:0] i, input logic [31:0] e, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] v;
		logic [1:0] rs;
		@(posedge sys_clk);
		s_axi_araddr <= {22'h0, i, 2'h0};
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		tr = 1'b0;
		for (int k = 0; k < 50 && !tr; k++) begin
			@(negedge sys_clk);
			{ta, tr, v, rs} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge sys_clk);
			if (ta) s_axi_arvalid <= 1'b0;
			if (tr) s_axi_rready <= 1'b0;
		end
		if (!tr) begin
			num_errors++;
			test_done();
		end
		chk("rdata", e, v);
		chk("rresp", 32'(er), 32'(rs));
	endtask
	task automatic hit(input logic [15:0] a, input logic [15:0] d, input logic r, input logic f, input logic [2:0] e);
		logic [2:0] g;
		u_core.cycle(a, d, r, f, g);
		chk("swi bdm tag", 32'(e), 32'(g));
	endtask
	initial begin
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		for (int i = 32; i < 38; i++) rd(8'(i), 32'h0, hbc_pkg::RESP_OKAY);
		wr(8'h20, 8'hFF);
		rd(8'h20, 32'hEC, hbc_pkg::RESP_OKAY);
		wr(8'h21, 8'hFF);
		rd(8'h21, 32'h7F, hbc_pkg::RESP_OKAY);
		rd(8'h30, 32'h0, hbc_pkg::RESP_SLVERR);
		$display("test registers done");
		wr(8'h20, 8'h00);
		wr(8'h21, 8'h00);
		wr(8'h22, 8'h12);
		@(posedge sys_clk) background_debug_enabled <= 1'b1;
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b000);
		wr(8'h20, 8'h80);
		hit(16'h12FF, 16'h0, 1'b1, 1'b0, 3'b010);
		hit(16'h1334, 16'h0, 1'b1, 1'b0, 3'b000);
		wr(8'h20, 8'h84);
		wr(8'h23, 8'h34);
		hit(16'h1235, 16'h0, 1'b1, 1'b0, 3'b000);
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b010);
		wr(8'h21, 8'h40);
		wr(8'h24, 8'hAB);
		wr(8'h25, 8'hCD);
		hit(16'h1234, 16'hABCD, 1'b1, 1'b0, 3'b010);
		hit(16'h1234, 16'hABCE, 1'b1, 1'b0, 3'b000);
		wr(8'h21, 8'h50);
		hit(16'h1234, 16'hABCE, 1'b1, 1'b0, 3'b010);
		hit(16'h1234, 16'hACCE, 1'b1, 1'b0, 3'b000);
		wr(8'h21, 8'h70);
		hit(16'h1234, 16'hACCE, 1'b1, 1'b0, 3'b010);
		wr(8'h21, 8'h03);
		hit(16'h1234, 16'h0, 1'b0, 1'b0, 3'b000);
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b010);
		@(posedge sys_clk) background_debug_enabled <= 1'b0;
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b000);
		@(posedge sys_clk) {background_debug_enabled, background_debug_active} <= 2'b11;
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b000);
		@(posedge sys_clk) background_debug_active <= 1'b0;
		wr(8'h20, 8'hA4);
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b000);
		hit(16'h1234, 16'h0, 1'b1, 1'b1, 3'b001);
		@(posedge sys_clk) background_debug_enabled <= 1'b0;
		hit(16'h1234, 16'h0, 1'b1, 1'b1, 3'b000);
		@(posedge sys_clk) background_debug_enabled <= 1'b1;
		$display("test full mode done");
		wr(8'h20, 8'h44);
		wr(8'h21, 8'h02);
		hit(16'h1234, 16'h0, 1'b1, 1'b1, 3'b101);
		hit(16'h1234, 16'h0, 1'b1, 1'b0, 3'b000);
		wr(8'h24, 8'h56);
		hit(16'h5634, 16'h0, 1'b1, 1'b1, 3'b000);
		wr(8'h21, 8'h40);
		hit(16'h5699, 16'h0, 1'b1, 1'b1, 3'b101);
		wr(8'h20, 8'h4C);
		wr(8'h25, 8'h78);
		hit(16'h5679, 16'h0, 1'b1, 1'b1, 3'b000);
		hit(16'h5678, 16'h0, 1'b1, 1'b1, 3'b101);
		wr(8'h20, 8'hC8);
		wr(8'h21, 8'h4C);
		hit(16'h5678, 16'h0, 1'b0, 1'b0, 3'b000);
		hit(16'h5678, 16'h0, 1'b1, 1'b0, 3'b010);
		$display("test dual modes done");
		s_axi_wstrb <= 4'h0;
		wr(8'h22, 8'h55);
		s_axi_wstrb <= 4'hF;
		rd(8'h22, 32'h12, hbc_pkg::RESP_OKAY);
		rd(hbc_pkg::IDX_STATUS, 32'h3, hbc_pkg::RESP_OKAY);
		wr(hbc_pkg::IDX_STATUS, 8'h03);
		rd(hbc_pkg::IDX_STATUS, 32'h0, hbc_pkg::RESP_OKAY);
		$display("test status done");
		test_done();
	end
endmodule
